// [rtl/dli_lamp.sv]
/*
  Diagnostic lamp and error indicator: mirrors one punch-section sensor on
  the sensor state lamp during a group 14 test, and shows the top-priority
  pending error as blink counts on the two error lamps.
  Assumes sensors are asynchronous pins; error sources and test requests
  come from logic on CORE_CLK.
*/
`include "dli_regs.svh"

module dli_lamp #(
  parameter int CYC_PER_MS = `DLI_CYC_PER_MS
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Test request
  input wire logic TEST_START,
  input wire dli_pkg::dli_digit_t TEST_GROUP,
  input wire dli_pkg::dli_digit_t TEST_SUB,
  input wire logic TEST_CANCEL,
  output logic TEST_RUNNING,
  output logic TEST_REFUSED,
  // Sensor pins
  input wire logic PUNCH_COVER_SENSOR,
  input wire logic TRAILING_EDGE_SENSOR_MAIN,
  input wire logic [3:0] TRAILING_EDGE_SENSOR_AUX,
  input wire logic [1:0] PUNCH_SKEW_SENSOR,
  input wire logic PUNCH_WASTE_FULL_SENSOR,
  // Error sources
  input wire logic HW_ERR_ACTIVE,
  input wire dli_pkg::dli_digit_t HW_ERR_DIGIT_ONE,
  input wire dli_pkg::dli_digit_t HW_ERR_DIGIT_TWO,
  input wire dli_pkg::dli_code_t HW_ERR_HOST_CODE,
  input wire logic [4:0] MISFEED_JAM,
  input wire logic ALERT_ACTIVE,
  input wire dli_pkg::dli_digit_t ALERT_DIGIT_ONE,
  input wire dli_pkg::dli_digit_t ALERT_DIGIT_TWO,
  input wire dli_pkg::dli_code_t ALERT_HOST_CODE,
  // Lamps and reported code
  output logic SENSOR_STATE_LAMP,
  output logic ERROR_DIGIT_ONE_LAMP,
  output logic ERROR_DIGIT_TWO_LAMP,
  output dli_pkg::dli_cat_t ERROR_CATEGORY,
  output dli_pkg::dli_code_t HOST_CODE
);
  import dli_pkg::*;

  localparam int NSENS = 9;
  localparam int DIV_W = $clog2(CYC_PER_MS + 1);

  logic [NSENS-1:0] sens_pin;
  logic [NSENS-1:0] sync1;
  logic [NSENS-1:0] sync2;
  logic [NSENS-1:0] sync3;
  logic [NSENS-1:0] sens;
  logic running;
  dli_digit_t sel;
  logic any_err;
  logic sub_ok;
  dli_cat_t next_cat;
  dli_digit_t next_d1;
  dli_digit_t next_d2;
  dli_code_t next_code;
  logic [15:0] next_on_ms;
  logic [DIV_W-1:0] ms_div;
  logic ms_tick;
  dli_blink_t bl;
  logic [15:0] phase_ms;
  logic [15:0] on_ms;
  dli_digit_t cnt;
  dli_digit_t d1;
  dli_digit_t d2;
  logic phase_end;

  // Sensor order matches sub-test numbers 1 to 9
  assign sens_pin = {PUNCH_WASTE_FULL_SENSOR, PUNCH_SKEW_SENSOR, TRAILING_EDGE_SENSOR_AUX,
                     TRAILING_EDGE_SENSOR_MAIN, PUNCH_COVER_SENSOR};

  // Three-stage capture; a level is taken only once stages two and three agree,
  // which keeps a metastable first stage away from the lamp
  genvar gi;
  generate
    for (gi = 0; gi < NSENS; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          sens[gi] <= 1'b0;
        end else begin
          sync1[gi] <= sens_pin[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            sens[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // Error priority and misfeed code table
  always_comb begin
    next_cat = DLI_CAT_NONE;
    next_d1 = 4'h0;
    next_d2 = 4'h0;
    next_code = 16'h0000;
    next_on_ms = `DLI_AL_ON_MS;
    if (HW_ERR_ACTIVE) begin
      next_cat = DLI_CAT_HW;
      next_d1 = HW_ERR_DIGIT_ONE;
      next_d2 = HW_ERR_DIGIT_TWO;
      next_code = HW_ERR_HOST_CODE;
      next_on_ms = `DLI_HW_ON_MS;
    end else if (MISFEED_JAM != 5'h00) begin
      next_cat = DLI_CAT_MISFEED;
      next_on_ms = `DLI_MF_ON_MS;
      if (MISFEED_JAM[0]) begin
        next_d1 = `DLI_MF_REMAIN_D1;
        next_d2 = `DLI_MF_REMAIN_D2;
        next_code = `DLI_MF_REMAIN_HOST;
      end else if (MISFEED_JAM[1]) begin
        next_d1 = `DLI_MF_DELAY_D1;
        next_d2 = `DLI_MF_DELAY_D2;
        next_code = `DLI_MF_DELAY_HOST;
      end else if (MISFEED_JAM[2]) begin
        next_d1 = `DLI_MF_TRAY_D1;
        next_d2 = `DLI_MF_TRAY_D2;
        next_code = `DLI_MF_TRAY_HOST;
      end else if (MISFEED_JAM[3]) begin
        next_d1 = `DLI_MF_BELT_D1;
        next_d2 = `DLI_MF_BELT_D2;
        next_code = `DLI_MF_BELT_HOST;
      end else begin
        next_d1 = `DLI_MF_BUFFER_D1;
        next_d2 = `DLI_MF_BUFFER_D2;
        next_code = `DLI_MF_BUFFER_HOST;
      end
    end else if (ALERT_ACTIVE) begin
      next_cat = DLI_CAT_ALERT;
      next_d1 = ALERT_DIGIT_ONE;
      next_d2 = ALERT_DIGIT_TWO;
      next_code = ALERT_HOST_CODE;
    end
  end

  assign any_err = HW_ERR_ACTIVE | (MISFEED_JAM != 5'h00) | ALERT_ACTIVE;
  assign sub_ok = (TEST_SUB >= `DLI_SUB_FIRST) && (TEST_SUB <= `DLI_SUB_LAST);

  // Test control; an error arising mid-test also ends the test
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      running <= 1'b0;
      sel <= 4'h0;
      TEST_REFUSED <= 1'b0;
    end else begin
      TEST_REFUSED <= 1'b0;
      if (TEST_CANCEL || any_err) begin
        running <= 1'b0;
        if (TEST_START && !TEST_CANCEL) begin
          TEST_REFUSED <= 1'b1;
        end
      end else if (TEST_START) begin
        if (TEST_GROUP == `DLI_GROUP_PUNCH && sub_ok) begin
          running <= 1'b1;
          sel <= TEST_SUB - 4'h1;
        end else begin
          TEST_REFUSED <= 1'b1;
        end
      end
    end
  end

  assign TEST_RUNNING = running;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      SENSOR_STATE_LAMP <= 1'b0;
    end else begin
      SENSOR_STATE_LAMP <= running && sens[sel];
    end
  end

  // Millisecond enable; the long divide is a parameter so benches can shorten it
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      if (ms_div == DIV_W'(CYC_PER_MS - 1)) begin
        ms_div <= '0;
        ms_tick <= 1'b1;
      end else begin
        ms_div <= ms_div + 1'b1;
      end
    end
  end

  always_comb begin
    unique case (bl)
      DLI_BL_D1_ON, DLI_BL_D2_ON: phase_end = (phase_ms >= on_ms);
      DLI_BL_PAUSE: phase_end = (phase_ms >= `DLI_PAUSE_MS);
      default: phase_end = (phase_ms >= `DLI_OFF_MS);
    endcase
  end

  // Blink sequencer: digits are captured at the start of each round so a
  // change of error never tears a pattern midway; clearing all errors ends it at once
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      bl <= DLI_BL_IDLE;
      phase_ms <= 16'h0000;
      cnt <= 4'h0;
      d1 <= 4'h0;
      d2 <= 4'h0;
      on_ms <= `DLI_AL_ON_MS;
      ERROR_CATEGORY <= DLI_CAT_NONE;
      HOST_CODE <= 16'h0000;
    end else if (!any_err) begin
      bl <= DLI_BL_IDLE;
      phase_ms <= 16'h0000;
      ERROR_CATEGORY <= DLI_CAT_NONE;
      HOST_CODE <= 16'h0000;
    end else if (bl == DLI_BL_IDLE || (bl == DLI_BL_PAUSE && ms_tick && phase_end)) begin
      bl <= DLI_BL_D1_ON;
      phase_ms <= 16'h0000;
      cnt <= 4'h1;
      d1 <= next_d1;
      d2 <= next_d2;
      on_ms <= next_on_ms;
      ERROR_CATEGORY <= next_cat;
      HOST_CODE <= next_code;
    end else if (ms_tick) begin
      phase_ms <= phase_ms + 16'h0001;
      if (phase_end) begin
        phase_ms <= 16'h0000;
        unique case (bl)
          DLI_BL_D1_ON: bl <= DLI_BL_D1_OFF;
          DLI_BL_D1_OFF: begin
            if (cnt >= d1) begin
              bl <= DLI_BL_D2_ON;
              cnt <= 4'h1;
            end else begin
              bl <= DLI_BL_D1_ON;
              cnt <= cnt + 4'h1;
            end
          end
          DLI_BL_D2_ON: bl <= DLI_BL_D2_OFF;
          DLI_BL_D2_OFF: begin
            if (cnt >= d2) begin
              bl <= DLI_BL_PAUSE;
            end else begin
              bl <= DLI_BL_D2_ON;
              cnt <= cnt + 4'h1;
            end
          end
          default: bl <= DLI_BL_IDLE;
        endcase
      end
    end
  end

  assign ERROR_DIGIT_ONE_LAMP = (bl == DLI_BL_D1_ON);
  assign ERROR_DIGIT_TWO_LAMP = (bl == DLI_BL_D2_ON);
endmodule

// [rtl/dli_pkg.sv]
/*
  Types of the diagnostic lamp and error indicator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dli_pkg;
  typedef logic [15:0] dli_code_t;
  typedef logic [3:0] dli_digit_t;

  typedef enum logic [1:0] {
    DLI_CAT_NONE = 2'h0,
    DLI_CAT_ALERT = 2'h1,
    DLI_CAT_MISFEED = 2'h2,
    DLI_CAT_HW = 2'h3
  } dli_cat_t;

  // Gray codes along the blink sequence, except the DLI_BL_PAUSE to DLI_BL_D1_ON restart
  typedef enum logic [2:0] {
    DLI_BL_IDLE = 3'h0,
    DLI_BL_D1_ON = 3'h1,
    DLI_BL_D1_OFF = 3'h3,
    DLI_BL_D2_ON = 3'h2,
    DLI_BL_D2_OFF = 3'h6,
    DLI_BL_PAUSE = 3'h7
  } dli_blink_t;
endpackage

// [rtl/dli_regs.svh]
/*
  Constants of the diagnostic lamp and error indicator: test numbers,
  misfeed code pairs with their host codes, and blink timing.
  Assumes inclusion by dli_lamp.sv only; the package holds no constants.
*/
`ifndef DLI_REGS_SVH
`define DLI_REGS_SVH

// Test selection
`define DLI_GROUP_PUNCH 4'hE
`define DLI_SUB_FIRST 4'h1
`define DLI_SUB_LAST 4'h9

// Misfeed code pairs and host codes
`define DLI_MF_REMAIN_D1 4'h1
`define DLI_MF_REMAIN_D2 4'h1
`define DLI_MF_REMAIN_HOST 16'hEA31
`define DLI_MF_DELAY_D1 4'h1
`define DLI_MF_DELAY_D2 4'h3
`define DLI_MF_DELAY_HOST 16'hEA10
`define DLI_MF_TRAY_D1 4'h1
`define DLI_MF_TRAY_D2 4'h7
`define DLI_MF_TRAY_HOST 16'hEA40
`define DLI_MF_BELT_D1 4'h2
`define DLI_MF_BELT_D2 4'h8
`define DLI_MF_BELT_HOST 16'hEA70
`define DLI_MF_BUFFER_D1 4'h3
`define DLI_MF_BUFFER_D2 4'h1
`define DLI_MF_BUFFER_HOST 16'hED16

// Timing: clock rate, millisecond tick, blink phases in milliseconds
`define DLI_CLK_HZ 100000000
`define DLI_MS_PER_S 1000
`define DLI_CYC_PER_MS (`DLI_CLK_HZ / `DLI_MS_PER_S)
`define DLI_HW_ON_MS 16'd200
`define DLI_MF_ON_MS 16'd400
`define DLI_AL_ON_MS 16'd800
`define DLI_OFF_MS 16'd300
`define DLI_PAUSE_MS 16'd1500

`endif

// [verif/dli_lamp_assertions.sv]
/*
  Checker for the dli_lamp ports: test handshake, error priority and lamps.
  Assumes it is bound onto dli_lamp and sees only that module's ports.
*/
module dli_lamp_assertions
  import dli_pkg::*;
(
  // Clock, reset and test port
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic TEST_START,
  input wire dli_pkg::dli_digit_t TEST_GROUP,
  input wire dli_pkg::dli_digit_t TEST_SUB,
  input wire logic TEST_CANCEL,
  input wire logic TEST_RUNNING,
  input wire logic TEST_REFUSED,
  // Errors and lamps
  input wire logic HW_ERR_ACTIVE,
  input wire logic [4:0] MISFEED_JAM,
  input wire logic ALERT_ACTIVE,
  input wire logic SENSOR_STATE_LAMP,
  input wire logic ERROR_DIGIT_ONE_LAMP,
  input wire logic ERROR_DIGIT_TWO_LAMP,
  input wire dli_pkg::dli_cat_t ERROR_CATEGORY,
  input wire dli_pkg::dli_code_t HOST_CODE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic err;
  logic req_ok;
  logic go;
  logic idle;
  assign err = HW_ERR_ACTIVE | ALERT_ACTIVE | (|MISFEED_JAM);
  assign req_ok = TEST_GROUP == 4'hE && TEST_SUB >= 4'h1 && TEST_SUB <= 4'h9;
  assign go = TEST_START && !TEST_CANCEL;
  assign idle = ERROR_CATEGORY == DLI_CAT_NONE;
  property p_run;
    go && !err && req_ok |=> TEST_RUNNING && !TEST_REFUSED;
  endproperty
  a_run: assert property (p_run) else $error("valid start not run");
  property p_busy;
    go && err && !TEST_RUNNING |=> TEST_REFUSED && !TEST_RUNNING;
  endproperty
  a_busy: assert property (p_busy) else $error("start during error not refused");
  property p_bad;
    go && !req_ok && !TEST_RUNNING |=> TEST_REFUSED;
  endproperty
  a_bad: assert property (p_bad) else $error("bad test number not refused");
  property p_hold;
    TEST_RUNNING && !TEST_CANCEL && !TEST_START && !err |=> TEST_RUNNING;
  endproperty
  a_hold: assert property (p_hold) else $error("test stopped by itself");
  property p_cancel;
    TEST_CANCEL |=> !TEST_RUNNING ##1 !SENSOR_STATE_LAMP;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel not obeyed");
  property p_hw;
    idle && HW_ERR_ACTIVE |=> ERROR_CATEGORY == DLI_CAT_HW && ERROR_DIGIT_ONE_LAMP;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware error not shown first");
  property p_mf;
    idle && !HW_ERR_ACTIVE && (|MISFEED_JAM) |=> ERROR_CATEGORY == DLI_CAT_MISFEED;
  endproperty
  a_mf: assert property (p_mf) else $error("misfeed not above alert");
  property p_clear;
    !err && !idle |=> idle && !ERROR_DIGIT_ONE_LAMP && !ERROR_DIGIT_TWO_LAMP
      && HOST_CODE == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("lamps stay after errors clear");
  c_refused: cover property (TEST_REFUSED);
  c_hw: cover property (ERROR_CATEGORY == DLI_CAT_HW);
  c_lit: cover property (TEST_RUNNING && SENSOR_STATE_LAMP);
endmodule

bind dli_lamp dli_lamp_assertions i_chk (.CORE_CLK, .RST_N, .TEST_START, .TEST_GROUP, .TEST_SUB,
  .TEST_CANCEL, .TEST_RUNNING, .TEST_REFUSED, .HW_ERR_ACTIVE, .MISFEED_JAM, .ALERT_ACTIVE,
  .SENSOR_STATE_LAMP, .ERROR_DIGIT_ONE_LAMP, .ERROR_DIGIT_TWO_LAMP, .ERROR_CATEGORY, .HOST_CODE);

// [verif/dli_sensor_model.sv]
/*
  Model of the punch-section sensor pins that feed dli_lamp.
  Assumes the bench asks for one level bit per sensor, in sub-test order.
*/
module dli_sensor_model #(
  parameter int DLY = 2
) (
  // Requested levels, bit 0 is sub-test 1
  input wire logic [8:0] level,
  // Sensor pins
  output logic PUNCH_COVER_SENSOR,
  output logic TRAILING_EDGE_SENSOR_MAIN,
  output logic [3:0] TRAILING_EDGE_SENSOR_AUX,
  output logic [1:0] PUNCH_SKEW_SENSOR,
  output logic PUNCH_WASTE_FULL_SENSOR
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins move a little after the request, never on a clock edge
  assign #DLY {PUNCH_WASTE_FULL_SENSOR, PUNCH_SKEW_SENSOR, TRAILING_EDGE_SENSOR_AUX,
    TRAILING_EDGE_SENSOR_MAIN, PUNCH_COVER_SENSOR} = level;
endmodule

// [verif/test_dli_lamp.sv]
/*
  Bench for dli_lamp: sensor mirroring, refusals and error blink codes.
  Assumes dli_sensor_model and the bound checker are compiled with it.
*/
module test_dli_lamp;
  timeunit 1ns;
  timeprecision 100ps;
  import dli_pkg::*;
  // A two-cycle millisecond keeps each blink round to about 6000 to 17000 cycles
  localparam int CPM = 2;
  logic CORE_CLK = 1'h0, RST_N = 1'h0, TEST_START = 1'h0, TEST_CANCEL = 1'h0;
  logic HW_ERR_ACTIVE = 1'h0, ALERT_ACTIVE = 1'h0;
  logic TEST_RUNNING, TEST_REFUSED, SENSOR_STATE_LAMP, ERROR_DIGIT_ONE_LAMP, ERROR_DIGIT_TWO_LAMP;
  logic PUNCH_COVER_SENSOR, TRAILING_EDGE_SENSOR_MAIN, PUNCH_WASTE_FULL_SENSOR;
  logic [3:0] TRAILING_EDGE_SENSOR_AUX;
  logic [1:0] PUNCH_SKEW_SENSOR;
  logic [4:0] MISFEED_JAM = 5'h00;
  logic [8:0] level = 9'h000;
  dli_digit_t TEST_GROUP = 4'hE, TEST_SUB = 4'h1, HW_ERR_DIGIT_ONE = 4'h2, HW_ERR_DIGIT_TWO = 4'h1;
  dli_digit_t ALERT_DIGIT_ONE = 4'h1, ALERT_DIGIT_TWO = 4'h0;
  dli_code_t HW_ERR_HOST_CODE = 16'hABC1, ALERT_HOST_CODE = 16'hABC2, HOST_CODE;
  dli_cat_t ERROR_CATEGORY;
  logic [7:0] bad [4] = '{8'hD1, 8'hE0, 8'hEA, 8'hF9};
  int d1s [5] = '{1, 1, 1, 2, 3};
  int d2s [5] = '{1, 3, 7, 8, 1};
  dli_code_t hosts [5] = '{16'hEA31, 16'hEA10, 16'hEA40, 16'hEA70, 16'hED16};
  int errors = 0, samples_checked = 0, cycles = 0, n1, n2, len;
  always #5 CORE_CLK = ~CORE_CLK;
  dli_sensor_model i_sens (.level, .PUNCH_COVER_SENSOR, .TRAILING_EDGE_SENSOR_MAIN,
    .TRAILING_EDGE_SENSOR_AUX, .PUNCH_SKEW_SENSOR, .PUNCH_WASTE_FULL_SENSOR);
  dli_lamp #(.CYC_PER_MS(CPM)) i_dut (.CORE_CLK, .RST_N, .TEST_START, .TEST_GROUP, .TEST_SUB,
    .TEST_CANCEL, .TEST_RUNNING, .TEST_REFUSED, .PUNCH_COVER_SENSOR, .TRAILING_EDGE_SENSOR_MAIN,
    .TRAILING_EDGE_SENSOR_AUX, .PUNCH_SKEW_SENSOR, .PUNCH_WASTE_FULL_SENSOR, .HW_ERR_ACTIVE,
    .HW_ERR_DIGIT_ONE, .HW_ERR_DIGIT_TWO, .HW_ERR_HOST_CODE, .MISFEED_JAM, .ALERT_ACTIVE,
    .ALERT_DIGIT_ONE, .ALERT_DIGIT_TWO, .ALERT_HOST_CODE, .SENSOR_STATE_LAMP,
    .ERROR_DIGIT_ONE_LAMP, .ERROR_DIGIT_TWO_LAMP, .ERROR_CATEGORY, .HOST_CODE);
  task automatic tick(input int n = 1);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic start(input dli_digit_t g, input dli_digit_t s);
    TEST_GROUP = g;
    TEST_SUB = s;
    TEST_START = 1'h1;
    tick();
    TEST_START = 1'h0;
  endtask
  // One round ends once both lamps stay dark longer than any gap between blinks
  task automatic blinks(input int a, input int b, input int ms, input dli_code_t code,
      input dli_cat_t cat);
    int low = 0;
    bit p1 = 0, p2 = 0;
    tick();
    check("category", ERROR_CATEGORY, cat);
    check("host code", HOST_CODE, code);
    {n1, n2, len} = '0;
    while (n2 == 0 || low < 1000 * CPM) begin
      tick();
      n1 += int'(ERROR_DIGIT_ONE_LAMP === 1'h1 && !p1);
      n2 += int'(ERROR_DIGIT_TWO_LAMP === 1'h1 && !p2);
      len += int'(n2 == 0 && n1 == 1 && ERROR_DIGIT_ONE_LAMP === 1'h1);
      low = (ERROR_DIGIT_ONE_LAMP === 1'h0 && ERROR_DIGIT_TWO_LAMP === 1'h0) ? low + 1 : 0;
      p1 = ERROR_DIGIT_ONE_LAMP === 1'h1;
      p2 = ERROR_DIGIT_TWO_LAMP === 1'h1;
    end
    check("digit one", n1, a);
    check("digit two", n2, b);
    check("on time", len >= (ms - 2) * CPM && len <= (ms + 1) * CPM, 1'h1);
    // Past the 300 ms gap and the 1500 ms pause, inside the next digit-one blink
    tick(900 * CPM);
    check("repeat", ERROR_DIGIT_ONE_LAMP, 1'h1);
    {MISFEED_JAM, HW_ERR_ACTIVE, ALERT_ACTIVE} = '0;
    tick(2);
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run needs about 78000 cycles
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    tick(4);
    RST_N = 1'h1;
    for (int s = 1; s <= 9; s++) begin
      start(4'hE, 4'(s));
      check("running", TEST_RUNNING, 1'h1);
      level = 9'h001 << (s - 1);
      tick(5);
      check("lamp lit", SENSOR_STATE_LAMP, 1'h1);
      level = ~(9'h001 << (s - 1));
      tick(5);
      check("lamp dark", SENSOR_STATE_LAMP, 1'h0);
    end
    level = 9'h1FF;
    tick(50);
    check("still running", {TEST_RUNNING, SENSOR_STATE_LAMP}, 2'h3);
    TEST_CANCEL = 1'h1;
    tick();
    TEST_CANCEL = 1'h0;
    check("cancelled", TEST_RUNNING, 1'h0);
    tick();
    check("lamp off", SENSOR_STATE_LAMP, 1'h0);
    foreach (bad[i]) begin
      start(bad[i][7:4], bad[i][3:0]);
      check("bad refused", {TEST_REFUSED, TEST_RUNNING}, 2'h2);
      // Let an edge pass so the strobe is never dropped and raised in one step
      tick();
    end
    $display("test sensors done");
    foreach (hosts[i]) begin
      MISFEED_JAM = 5'h01 << i;
      blinks(d1s[i], d2s[i], 400, hosts[i], DLI_CAT_MISFEED);
    end
    $display("test misfeed codes done");
    {HW_ERR_ACTIVE, ALERT_ACTIVE, MISFEED_JAM} = {2'h3, 5'h02};
    start(4'hE, 4'h1);
    check("busy refused", {TEST_REFUSED, TEST_RUNNING}, 2'h2);
    blinks(2, 1, 200, 16'hABC1, DLI_CAT_HW);
    {ALERT_ACTIVE, MISFEED_JAM} = {1'h1, 5'h02};
    blinks(1, 3, 400, 16'hEA10, DLI_CAT_MISFEED);
    ALERT_ACTIVE = 1'h1;
    blinks(1, 1, 800, 16'hABC2, DLI_CAT_ALERT);
    start(4'hE, 4'h9);
    check("runs after clear", TEST_RUNNING, 1'h1);
    $display("test priority done");
    summarize();
  end
endmodule
